// ==== pkg/evsel_pkg.sv ====
// Purpose: Constants for the hub event selection and counting block
// Assumes: 32-bit AXI4-Lite register bus, four counters
// Notes: Offsets are byte addresses
`default_nettype none
package evsel_pkg;
  localparam int NUM_CNT = 4;
  localparam int NARROW_CNT = 2;
  localparam int FILT_W = 15;
  localparam int PORT_BITS = 12;
  localparam int DBG_W = 32;
  localparam int INC_W = 11;
  localparam int CTL_EN_BIT = 22;
  // Event codes
  localparam logic [7:0] EV_CARD_DW = 8'h83;
  localparam logic [7:0] EV_ASK = 8'h86;
  localparam logic [7:0] EV_GRANT = 8'h87;
  localparam logic [7:0] EV_TC = 8'h40;
  localparam logic [7:0] EV_WC = 8'h41;
  localparam logic [7:0] EV_INV = 8'h43;
  localparam logic [7:0] EV_DBG_AND = 8'h02;
  // Subevent select masks and port filter prefix
  localparam logic [7:0] UM_MESSAGE = 8'h40;
  localparam logic [7:0] UM_CPL_DATA = 8'h80;
  localparam logic [7:0] UM_ATOMIC = 8'h10;
  localparam logic [7:0] UM_OWN = 8'h04;
  localparam logic [7:0] UM_WALKS_FULL = 8'h80;
  localparam logic [7:0] UM_NON_PCIE = 8'h01;
  localparam logic [7:0] POSTED_ONLY = 8'h34;
  localparam logic [2:0] FILT_PREFIX = 3'h7;
  // Register map
  localparam logic [7:0] OFF_CTL = 8'h00;
  localparam logic [7:0] OFF_FILT = 8'h04;
  localparam logic [7:0] OFF_CNT = 8'h08;
  localparam logic [7:0] CNT_STRIDE = 8'h10;
  localparam logic [7:0] OFF_MASK = 8'h40;
  localparam logic [7:0] OFF_MATCH = 8'h44;
  localparam logic [7:0] OFF_STATUS = 8'h48;
  // Reset values and response codes
  localparam logic [31:0] CTL_RST = 32'h0;
  localparam logic [14:0] FILT_RST = 15'h0;
  localparam logic [31:0] MASK_RST = 32'h0;
  localparam logic [31:0] MATCH_RST = 32'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ==== src/io_hub_event_selection.sv ====
// Purpose: Event selection and counting for the hub performance monitor
// Assumes: Event inputs come from logic on clk, no synchronising needed
// Notes: Counters wrap; a software write to a counter beats its increment
//
// Summary of operation
// - Card dword event counts message traffic when subevent bit 6 set.
// - Card dword event counts completion data when subevent bit 7 set.
// - Card dword event counts DRAM atomics when subevent bit 4 set.
// - Port filter needs prefix 111, then one bit per port, port 0 lowest.
// - Event 0x86 counts pipeline entry asks, one per cycle, counters 0-3.
// - Event 0x87 counts pipeline entry grants, one per cycle, counters 0-3.
// - Arbitration subevent bits select the pipeline stage counted.
// - Ownership, line write and data subevents count posted requests only.
// - Event 0x40 counts first buffer lookups or all lookups.
// - Event 0x40 counts first-lookup hits on 4K, 2M, 1G pages.
// - Event 0x40 bit 5 counts translation buffer fills after misses.
// - Event 0x40 counts root context cache lookups and first-lookup hits.
// - Event 0x41 counts walk cache lookups and first-lookup hits per level.
// - Event 0x41 bit 4 counts walk cache fills on fill-valid.
// - Event 0x41 bit 5 counts IOMMU memory fetches after misses.
// - Event 0x41 bit 7 counts every cycle page walk tracker is full.
// - Event 0x43 counts global, domain and page buffer invalidations.
// - Event 0x43 counts global, domain, device context cache invalidations.
// - Event 0x43 counts interrupt cache lookups and first-lookup hits.
// - Event 0x02 counts all-bits debug match, counters 0-1 only.
// - Debug subevent bits pick bus match or combinations of both buses.
// - Event 0x83 adds requested dwords, up to 1024, counters 0-1 only.
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module io_hub_event_selection #(
  parameter int CW = 32,
  parameter int AW = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cdr_valid,
  input wire logic [7:0] cdr_kind,
  input wire logic [3:0] cdr_port,
  input wire logic [10:0] cdr_dwords,
  input wire logic ask_valid,
  input wire logic [7:0] ask_stage,
  input wire logic ask_posted,
  input wire logic [3:0] ask_port,
  input wire logic grant_valid,
  input wire logic [7:0] grant_stage,
  input wire logic grant_posted,
  input wire logic [3:0] grant_port,
  input wire logic [7:0] tc_events,
  input wire logic [7:0] wc_events,
  input wire logic [7:0] inv_events,
  input wire logic [31:0] non_pcie_bus,
  input wire logic [31:0] pcie_bus
);
  localparam int NC = evsel_pkg::NUM_CNT;

  typedef struct packed {
    logic aw_got;
    logic [AW-1:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [NC-1:0][31:0] ctl;
    logic [NC-1:0][14:0] filt;
    logic [NC-1:0][CW-1:0] cnt;
    logic [31:0] mask;
    logic [31:0] match;
  } state_t;

  state_t st_q;
  state_t st_d;
  logic [1:0] rst_sync_q;
  logic rst_core_n;
  logic aw_take;
  logic w_take;
  logic wr_fire;
  logic [AW-1:0] wr_a;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic non_pcie_match;
  logic pcie_match;
  logic [7:0] cdr_hit;
  logic [7:0] ask_hit;
  logic [7:0] grant_hit;
  logic [7:0] dbg_cond;
  logic [NC-1:0][10:0] inc;
  logic [NC-1:0] misplaced;

  // Release reset through two flops so all state leaves reset together
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_core_n = rst_sync_q[1];

  function automatic logic port_ok(input logic [14:0] f, input logic [3:0] p);
    logic ok;
    ok = (f[14:12] == evsel_pkg::FILT_PREFIX);
    if (int'(p) >= evsel_pkg::PORT_BITS) begin
      ok = 1'b0;
    end
    return ok && f[p];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = n[8*b +: 8];
      end
    end
    return r;
  endfunction

  assign s_axi_awready = !st_q.aw_got && !st_q.bvalid;
  assign s_axi_wready = !st_q.w_got && !st_q.bvalid;
  assign s_axi_arready = !st_q.rvalid;
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rdata = st_q.rdata;
  assign s_axi_rresp = st_q.rresp;

  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign wr_fire = (st_q.aw_got || aw_take) && (st_q.w_got || w_take);
  assign wr_a = st_q.aw_got ? st_q.aw_addr : s_axi_awaddr;
  assign wr_data = st_q.w_got ? st_q.w_data : s_axi_wdata;
  assign wr_strb = st_q.w_got ? st_q.w_strb : s_axi_wstrb;

  // All-match compare: every masked bit must equal its match bit
  assign non_pcie_match = ((non_pcie_bus ^ st_q.match) & st_q.mask) == 32'h0;
  assign pcie_match = ((pcie_bus ^ st_q.match) & st_q.mask) == 32'h0;

  always_comb begin
    cdr_hit = cdr_valid ? cdr_kind : 8'h0;
    // Non-posted traffic never reaches the posted-only stages
    ask_hit = ask_valid ? (ask_stage & ~(evsel_pkg::POSTED_ONLY & {8{~ask_posted}})) : 8'h0;
    grant_hit = grant_valid ?
                (grant_stage & ~(evsel_pkg::POSTED_ONLY & {8{~grant_posted}})) : 8'h0;
    dbg_cond = {2'h0, !non_pcie_match && !pcie_match, !non_pcie_match && pcie_match,
                non_pcie_match && pcie_match, non_pcie_match && !pcie_match,
                pcie_match, non_pcie_match};
  end

  always_comb begin
    logic [7:0] ev;
    logic [7:0] um;
    logic narrow;
    ev = 8'h0;
    um = 8'h0;
    narrow = 1'b0;
    for (int i = 0; i < NC; i++) begin
      ev = st_q.ctl[i][7:0];
      um = st_q.ctl[i][15:8];
      narrow = i < evsel_pkg::NARROW_CNT;
      misplaced[i] = !narrow && (ev == evsel_pkg::EV_CARD_DW || ev == evsel_pkg::EV_DBG_AND);
      inc[i] = 11'h0;
      case (ev)
        evsel_pkg::EV_CARD_DW: begin
          // Whole dword count in one cycle, hence the wide increment
          if (narrow && |(um & cdr_hit) && port_ok(st_q.filt[i], cdr_port)) begin
            inc[i] = cdr_dwords;
          end
        end
        evsel_pkg::EV_ASK: begin
          inc[i] = {10'h0, |(um & ask_hit) && port_ok(st_q.filt[i], ask_port)};
        end
        evsel_pkg::EV_GRANT: begin
          inc[i] = {10'h0, |(um & grant_hit) && port_ok(st_q.filt[i], grant_port)};
        end
        evsel_pkg::EV_TC: begin
          inc[i] = {10'h0, |(um & tc_events)};
        end
        evsel_pkg::EV_WC: begin
          inc[i] = {10'h0, |(um & wc_events)};
        end
        evsel_pkg::EV_INV: begin
          inc[i] = {10'h0, |(um & inv_events)};
        end
        evsel_pkg::EV_DBG_AND: begin
          inc[i] = {10'h0, narrow && |(um & dbg_cond)};
        end
        default: begin
          inc[i] = 11'h0;
        end
      endcase
      if (!st_q.ctl[i][evsel_pkg::CTL_EN_BIT]) begin
        inc[i] = 11'h0;
      end
    end
  end

  always_comb begin
    logic [7:0] ra;
    logic [7:0] wa;
    logic hit;
    st_d = st_q;
    ra = 8'(s_axi_araddr);
    wa = 8'(wr_a);
    hit = 1'b0;
    for (int i = 0; i < NC; i++) begin
      st_d.cnt[i] = st_q.cnt[i] + CW'(inc[i]);
    end
    if (aw_take) begin
      st_d.aw_got = 1'b1;
      st_d.aw_addr = s_axi_awaddr;
    end
    if (w_take) begin
      st_d.w_got = 1'b1;
      st_d.w_data = s_axi_wdata;
      st_d.w_strb = s_axi_wstrb;
    end
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end
    if (wr_fire) begin
      st_d.aw_got = 1'b0;
      st_d.w_got = 1'b0;
      st_d.bvalid = 1'b1;
      for (int i = 0; i < NC; i++) begin
        if (wa == evsel_pkg::OFF_CTL + 8'(i) * evsel_pkg::CNT_STRIDE) begin
          st_d.ctl[i] = merge(st_q.ctl[i], wr_data, wr_strb);
          hit = 1'b1;
        end
        if (wa == evsel_pkg::OFF_FILT + 8'(i) * evsel_pkg::CNT_STRIDE) begin
          st_d.filt[i] = 15'(merge({17'h0, st_q.filt[i]}, wr_data, wr_strb));
          hit = 1'b1;
        end
        if (wa == evsel_pkg::OFF_CNT + 8'(i) * evsel_pkg::CNT_STRIDE) begin
          st_d.cnt[i] = CW'(merge(32'(st_q.cnt[i]), wr_data, wr_strb));
          hit = 1'b1;
        end
      end
      if (wa == evsel_pkg::OFF_MASK) begin
        st_d.mask = merge(st_q.mask, wr_data, wr_strb);
        hit = 1'b1;
      end
      if (wa == evsel_pkg::OFF_MATCH) begin
        st_d.match = merge(st_q.match, wr_data, wr_strb);
        hit = 1'b1;
      end
      // Status is read-only; writing it is an error like an unmapped word
      st_d.bresp = hit ? evsel_pkg::RESP_OKAY : evsel_pkg::RESP_SLVERR;
    end
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      st_d.rvalid = 1'b1;
      st_d.rdata = 32'h0;
      st_d.rresp = evsel_pkg::RESP_SLVERR;
      for (int i = 0; i < NC; i++) begin
        if (ra == evsel_pkg::OFF_CTL + 8'(i) * evsel_pkg::CNT_STRIDE) begin
          st_d.rdata = st_q.ctl[i];
          st_d.rresp = evsel_pkg::RESP_OKAY;
        end
        if (ra == evsel_pkg::OFF_FILT + 8'(i) * evsel_pkg::CNT_STRIDE) begin
          st_d.rdata = {17'h0, st_q.filt[i]};
          st_d.rresp = evsel_pkg::RESP_OKAY;
        end
        if (ra == evsel_pkg::OFF_CNT + 8'(i) * evsel_pkg::CNT_STRIDE) begin
          st_d.rdata = 32'(st_q.cnt[i]);
          st_d.rresp = evsel_pkg::RESP_OKAY;
        end
      end
      if (ra == evsel_pkg::OFF_MASK) begin
        st_d.rdata = st_q.mask;
        st_d.rresp = evsel_pkg::RESP_OKAY;
      end
      if (ra == evsel_pkg::OFF_MATCH) begin
        st_d.rdata = st_q.match;
        st_d.rresp = evsel_pkg::RESP_OKAY;
      end
      if (ra == evsel_pkg::OFF_STATUS) begin
        st_d.rdata = {26'h0, pcie_match, non_pcie_match, misplaced};
        st_d.rresp = evsel_pkg::RESP_OKAY;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      st_q.aw_got <= 1'b0;
      st_q.aw_addr <= '0;
      st_q.w_got <= 1'b0;
      st_q.w_data <= 32'h0;
      st_q.w_strb <= 4'h0;
      st_q.bvalid <= 1'b0;
      st_q.bresp <= evsel_pkg::RESP_OKAY;
      st_q.rvalid <= 1'b0;
      st_q.rdata <= 32'h0;
      st_q.rresp <= evsel_pkg::RESP_OKAY;
      st_q.ctl <= {NC{evsel_pkg::CTL_RST}};
      st_q.filt <= {NC{evsel_pkg::FILT_RST}};
      st_q.cnt <= '0;
      st_q.mask <= evsel_pkg::MASK_RST;
      st_q.match <= evsel_pkg::MATCH_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // Checks on counter 0 (and 2 for placement)
  logic c0_on;
  logic c0_quiet;
  logic c2_quiet;
  logic [7:0] c0_um;
  logic [7:0] c0_ev;
  logic c0_cdr_port;
  assign c0_ev = st_q.ctl[0][7:0];
  assign c0_um = st_q.ctl[0][15:8];
  assign c0_on = st_q.ctl[0][evsel_pkg::CTL_EN_BIT];
  assign c0_quiet = !(wr_fire && 8'(wr_a) == evsel_pkg::OFF_CNT);
  assign c2_quiet = !(wr_fire && 8'(wr_a) == evsel_pkg::OFF_CNT + 8'h20);
  assign c0_cdr_port = port_ok(st_q.filt[0], cdr_port);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_core_n);

  a_msg_dwords: assert property (
    c0_on && c0_quiet && c0_ev == evsel_pkg::EV_CARD_DW && c0_um == evsel_pkg::UM_MESSAGE
    && cdr_valid && cdr_kind == evsel_pkg::UM_MESSAGE && c0_cdr_port
    |=> st_q.cnt[0] == $past(st_q.cnt[0]) + CW'($past(cdr_dwords)))
    else $error("message dwords not added");
  a_cpl_dwords: assert property (
    c0_on && c0_quiet && c0_ev == evsel_pkg::EV_CARD_DW
    && (c0_um & evsel_pkg::UM_CPL_DATA) != 8'h0
    && cdr_valid && cdr_kind == evsel_pkg::UM_CPL_DATA && c0_cdr_port
    |=> st_q.cnt[0] == $past(st_q.cnt[0]) + CW'($past(cdr_dwords)))
    else $error("completion dwords not added");
  a_atomic_only: assert property (
    c0_quiet && c0_ev == evsel_pkg::EV_CARD_DW && c0_um == evsel_pkg::UM_ATOMIC
    && (!cdr_valid || cdr_kind[4] == 1'b0)
    |=> $stable(st_q.cnt[0]))
    else $error("atomic count moved without atomic");
  a_filter_prefix: assert property (
    c0_quiet && c0_ev == evsel_pkg::EV_CARD_DW
    && st_q.filt[0][14:12] != evsel_pkg::FILT_PREFIX |=> $stable(st_q.cnt[0]))
    else $error("bad filter prefix still counted");
  a_ask_one: assert property (
    c0_quiet && c0_ev == evsel_pkg::EV_ASK
    |=> (st_q.cnt[0] - $past(st_q.cnt[0])) <= CW'(1))
    else $error("ask event added more than one");
  a_grant_stage: assert property (
    c0_on && c0_quiet && c0_ev == evsel_pkg::EV_GRANT && grant_valid && grant_posted
    && |(c0_um & grant_stage) && port_ok(st_q.filt[0], grant_port)
    |=> st_q.cnt[0] == $past(st_q.cnt[0]) + CW'(1))
    else $error("grant not counted");
  a_posted_only: assert property (
    c0_quiet && c0_ev == evsel_pkg::EV_ASK && (c0_um & evsel_pkg::UM_OWN) != 8'h0
    && (c0_um & ask_stage & ~evsel_pkg::POSTED_ONLY) == 8'h0
    && !(ask_valid && ask_posted) |=> $stable(st_q.cnt[0]))
    else $error("non-posted ownership counted");
  a_walks_full: assert property (
    (c0_on && c0_quiet && c0_ev == evsel_pkg::EV_WC && c0_um == evsel_pkg::UM_WALKS_FULL
    && wc_events[7])[*3] |=> st_q.cnt[0] == $past(st_q.cnt[0], 3) + CW'(3))
    else $error("full cycles not counted");
  a_place_limit: assert property (
    c2_quiet && (st_q.ctl[2][7:0] == evsel_pkg::EV_DBG_AND
    || st_q.ctl[2][7:0] == evsel_pkg::EV_CARD_DW) |=> $stable(st_q.cnt[2]))
    else $error("restricted event counted on counter 2");
  a_nonpcie_hit: assert property (
    c0_on && c0_quiet && c0_ev == evsel_pkg::EV_DBG_AND && c0_um == evsel_pkg::UM_NON_PCIE
    && non_pcie_match |=> st_q.cnt[0] == $past(st_q.cnt[0]) + CW'(1))
    else $error("debug match not counted");
  a_bresp_hold: assert property (
    st_q.bvalid && !s_axi_bready |=> st_q.bvalid && $stable(st_q.bresp))
    else $error("write response dropped early");

  c_dword_count: cover property (inc[0] > 11'h1);
  c_grant_count: cover property (c0_ev == evsel_pkg::EV_GRANT && inc[0] != 11'h0);
  c_debug_count: cover property (c0_ev == evsel_pkg::EV_DBG_AND && inc[0] != 11'h0);
  c_write_then_read: cover property (st_q.bvalid ##[1:4] st_q.rvalid);
endmodule
`default_nettype wire

// ==== verif/hub_event_source.sv ====
// Purpose: Far-side model of hub pipeline, IOMMU and debug bus events
// Assumes: Same clock as the block; driven just after rising edges
// Notes: Released payloads flip so stale values never pose as live ones
`timescale 1ns/1ps
`default_nettype none
module hub_event_source (
  input wire logic clk,
  output logic cdr_valid,
  output logic [7:0] cdr_kind,
  output logic [3:0] cdr_port,
  output logic [10:0] cdr_dwords,
  output logic ask_valid,
  output logic [7:0] ask_stage,
  output logic ask_posted,
  output logic [3:0] ask_port,
  output logic grant_valid,
  output logic [7:0] grant_stage,
  output logic grant_posted,
  output logic [3:0] grant_port,
  output logic [7:0] tc_events,
  output logic [7:0] wc_events,
  output logic [7:0] inv_events,
  output logic [31:0] non_pcie_bus,
  output logic [31:0] pcie_bus
);
  localparam logic [31:0] HIT = 32'h0000_1234;
  localparam logic [31:0] MISS = 32'h5A5A_ED5A;
  initial begin
    {cdr_valid, cdr_kind, cdr_port, cdr_dwords} = '0;
    {ask_valid, ask_stage, ask_posted, ask_port} = '0;
    {grant_valid, grant_stage, grant_posted, grant_port} = '0;
    {tc_events, wc_events, inv_events} = '0;
    non_pcie_bus = MISS;
    pcie_bus = MISS;
  end
  task automatic card(input logic [7:0] k, input logic [3:0] p, input logic [10:0] d);
    cdr_valid <= 1'b1;
    cdr_kind <= k;
    cdr_port <= p;
    cdr_dwords <= d;
    @(posedge clk);
    cdr_valid <= 1'b0;
    cdr_kind <= ~k;
    cdr_port <= ~p;
    cdr_dwords <= ~d;
    @(posedge clk);
  endtask
  task automatic arb(input bit g, input logic [7:0] s, input logic ps, input logic [3:0] p);
    if (g) begin
      {grant_valid, grant_stage, grant_posted, grant_port} <= {1'b1, s, ps, p};
    end else begin
      {ask_valid, ask_stage, ask_posted, ask_port} <= {1'b1, s, ps, p};
    end
    @(posedge clk);
    {ask_valid, grant_valid} <= 2'h0;
    {ask_stage, ask_posted, ask_port} <= ~{s, ps, p};
    {grant_stage, grant_posted, grant_port} <= ~{s, ps, p};
    @(posedge clk);
  endtask
  task automatic grp(input int k, input logic [7:0] b, input int n);
    case (k)
      0: tc_events <= b;
      1: wc_events <= b;
      default: inv_events <= b;
    endcase
    repeat (n) @(posedge clk);
    {tc_events, wc_events, inv_events} <= '0;
    @(posedge clk);
  endtask
  task automatic dbg(input bit m0, input bit m1, input int n);
    non_pcie_bus <= m0 ? HIT : MISS;
    pcie_bus <= m1 ? HIT : MISS;
    repeat (n) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ==== verif/io_hub_event_selection_tb.sv ====
// Purpose: Self-checking bench for hub event selection over AXI4-Lite
// Assumes: Counter visible one cycle after its event
// Notes: rready held high; bready held low once to stall a write response
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s expected %0h seen %0h", n, e, g); end end
module io_hub_event_selection_tb;
  localparam logic [1:0] OK = evsel_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = evsel_pkg::RESP_SLVERR;
  localparam logic [31:0] EN = 32'h0000_0001 << evsel_pkg::CTL_EN_BIT;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr, araddr, codes [3];
  logic [31:0] wdata, rdata;
  logic awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic cdr_valid, ask_valid, ask_posted, grant_valid, grant_posted;
  logic [7:0] cdr_kind, ask_stage, grant_stage, tc_events, wc_events, inv_events;
  logic [3:0] cdr_port, ask_port, grant_port;
  logic [10:0] cdr_dwords;
  logic [31:0] non_pcie_bus, pcie_bus;
  logic [5:0] tbl;
  logic bready = 1'b1;
  logic [3:0] wstrb = 4'hF;
  int errors = 0;
  int checks = 0;
  always #4 clk = ~clk;
  io_hub_event_selection DUT (.clk(clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .cdr_valid(cdr_valid), .cdr_kind(cdr_kind), .cdr_port(cdr_port), .cdr_dwords(cdr_dwords),
    .ask_valid(ask_valid), .ask_stage(ask_stage), .ask_posted(ask_posted), .ask_port(ask_port),
    .grant_valid(grant_valid), .grant_stage(grant_stage), .grant_posted(grant_posted),
    .grant_port(grant_port), .tc_events(tc_events), .wc_events(wc_events),
    .inv_events(inv_events), .non_pcie_bus(non_pcie_bus), .pcie_bus(pcie_bus));
  hub_event_source src (.clk(clk), .cdr_valid(cdr_valid), .cdr_kind(cdr_kind),
    .cdr_port(cdr_port), .cdr_dwords(cdr_dwords), .ask_valid(ask_valid),
    .ask_stage(ask_stage), .ask_posted(ask_posted), .ask_port(ask_port),
    .grant_valid(grant_valid), .grant_stage(grant_stage), .grant_posted(grant_posted),
    .grant_port(grant_port), .tc_events(tc_events), .wc_events(wc_events),
    .inv_events(inv_events), .non_pcie_bus(non_pcie_bus), .pcie_bus(pcie_bus));
  task automatic end_sim;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit aw;
    bit w;
    aw = 1'b0;
    w = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (awvalid && awready) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!bvalid);
    `CHK("bresp", er, bresp)
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    `CHK("rdata", e, rdata)
    `CHK("rresp", er, rresp)
  endtask
  // Generous bound: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    end_sim;
  end
  initial begin
    {awaddr, araddr, wdata, awvalid, wvalid, arvalid} = '0;
    codes = '{evsel_pkg::EV_TC, evsel_pkg::EV_WC, evsel_pkg::EV_INV};
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(evsel_pkg::OFF_CTL, 32'h0, OK);
    rd(evsel_pkg::OFF_FILT, 32'h0, OK);
    rd(evsel_pkg::OFF_MASK, 32'h0, OK);
    rd(8'h4C, 32'h0, ERR);
    // Response must stand while bready is low
    bready <= 1'b0;
    wr(evsel_pkg::OFF_STATUS, 32'hFFFF_FFFF, ERR);
    bready <= 1'b1;
    // Card dword traffic, port filter and dword weight
    wr(evsel_pkg::OFF_FILT, 32'h0000_7001, OK);
    wr(evsel_pkg::OFF_CTL, EN | 32'h0000_4083, OK);
    src.card(8'h40, 4'h0, 11'h010);
    src.card(8'h40, 4'h1, 11'h007);
    src.card(8'h80, 4'h0, 11'h009);
    src.card(8'h40, 4'h0, 11'h400);
    rd(evsel_pkg::OFF_CNT, 32'h0000_0410, OK);
    wstrb <= 4'h2;
    wr(evsel_pkg::OFF_CNT, 32'hFFFF_FFFF, OK);
    wstrb <= 4'hF;
    rd(evsel_pkg::OFF_CNT, 32'h0000_FF10, OK);
    wr(evsel_pkg::OFF_CTL, EN | 32'h0000_9083, OK);
    wr(evsel_pkg::OFF_FILT, 32'h0000_7082, OK);
    wr(evsel_pkg::OFF_CNT, 32'h0, OK);
    src.card(8'h80, 4'h1, 11'h005);
    src.card(8'h10, 4'h7, 11'h003);
    src.card(8'h40, 4'h1, 11'h004);
    src.card(8'h10, 4'h2, 11'h006);
    rd(evsel_pkg::OFF_CNT, 32'h0000_0008, OK);
    wr(evsel_pkg::OFF_CTL, EN | 32'h0000_1083, OK);
    src.card(8'h80, 4'h1, 11'h005);
    src.card(8'h10, 4'h1, 11'h002);
    rd(evsel_pkg::OFF_CNT, 32'h0000_000A, OK);
    wr(evsel_pkg::OFF_FILT, 32'h0000_3082, OK);
    src.card(8'h10, 4'h1, 11'h005);
    rd(evsel_pkg::OFF_CNT, 32'h0000_000A, OK);
    // Pipeline entry asks and grants
    wr(evsel_pkg::OFF_FILT, 32'h0000_700F, OK);
    for (int g = 0; g < 2; g++) begin
      wr(evsel_pkg::OFF_CTL, EN | 32'h0500 | (g ? evsel_pkg::EV_GRANT : evsel_pkg::EV_ASK), OK);
      wr(evsel_pkg::OFF_CNT, 32'h0, OK);
      src.arb(g[0], 8'h01, 1'b0, 4'h0);
      src.arb(g[0], 8'h04, 1'b0, 4'h1);
      src.arb(g[0], 8'h04, 1'b1, 4'h3);
      src.arb(g[0], 8'h05, 1'b1, 4'h2);
      src.arb(g[0], 8'h01, 1'b1, 4'h4);
      src.arb(!g[0], 8'h01, 1'b1, 4'h0);
      src.arb(g[0], 8'h02, 1'b1, 4'h0);
      rd(evsel_pkg::OFF_CNT, 32'h0000_0003, OK);
    end
    // Translation, walk cache and invalidation groups, each subevent alone
    for (int k = 0; k < 3; k++) begin
      for (int n = 0; n < 8; n++) begin
        wr(evsel_pkg::OFF_CTL, EN | {16'h0, 8'h01 << n, codes[k]}, OK);
        wr(evsel_pkg::OFF_CNT, 32'h0, OK);
        src.grp(k, ~(8'h01 << n), 1);
        src.grp(k, 8'hFF, 3);
        rd(evsel_pkg::OFF_CNT, 32'h0000_0003, OK);
      end
    end
    wr(evsel_pkg::OFF_CTL, EN | 32'h0000_FF40, OK);
    wr(evsel_pkg::OFF_CNT, 32'h0, OK);
    src.grp(0, 8'hFF, 1);
    rd(evsel_pkg::OFF_CNT, 32'h0000_0001, OK);
    // Debug all-match; idle bus state keeps each subevent false
    wr(evsel_pkg::OFF_MASK, 32'h0000_FF00, OK);
    wr(evsel_pkg::OFF_MATCH, 32'h0000_1200, OK);
    for (int s = 0; s < 6; s++) begin
      for (int c = 0; c < 4; c++) begin
        tbl = {!c[0] && !c[1], !c[0] && c[1], c[0] && c[1], c[0] && !c[1], c[1], c[0]};
        src.dbg(s >= 4, s >= 4, 1);
        wr(evsel_pkg::OFF_CTL, EN | {16'h0, 8'h01 << s, evsel_pkg::EV_DBG_AND}, OK);
        wr(evsel_pkg::OFF_CNT, 32'h0, OK);
        src.dbg(c[0], c[1], 3);
        src.dbg(s >= 4, s >= 4, 1);
        rd(evsel_pkg::OFF_CNT, tbl[s] ? 32'h3 : 32'h0, OK);
      end
    end
    // Restricted events on upper counters never count
    src.dbg(1'b1, 1'b1, 1);
    wr(8'h24, 32'h0000_7FFF, OK);
    wr(8'h20, EN | 32'h0000_4083, OK);
    wr(8'h30, EN | 32'h0000_0102, OK);
    src.card(8'h40, 4'h0, 11'h010);
    rd(8'h28, 32'h0, OK);
    rd(8'h38, 32'h0, OK);
    rd(evsel_pkg::OFF_STATUS, 32'h0000_003C, OK);
    end_sim;
  end
endmodule
`default_nettype wire
